//--- shared/instruction_decode_regs.svh
// Purpose: Named constants for the instruction format decoder.
// Assumes: 12-bit instruction words, one instruction cycle of four clock periods.
// Notes: Field positions are fixed per category and never depend on runtime state.
// Notes on behaviour
// - Every instruction is one 12-bit word: opcode plus one or more operand fields.
// - Each word falls into exactly one of byte, bit, or literal/control categories.
// - Byte operations: destination bit 0 selects accumulator, 1 selects file register.
// - The file address operand selects a register location from 0x00 to 0x1f.
// - Bit operations: bit number picks one bit of the addressed 8-bit register.
// - Literal/control operations carry an 8-bit or 9-bit constant, per instruction.
// - Don't-care positions are ignored, so either value decodes identically.
// - One cycle per instruction, two when a test is true or PC changes.
// - Each instruction cycle is exactly four consecutive oscillator periods.
// - Any PC write except the unconditional branch forces the ninth PC bit to zero.
`ifndef INSTRUCTION_DECODE_REGS_SVH
`define INSTRUCTION_DECODE_REGS_SVH

`define WORD_W          12
`define FILE_ADDR_W     7
`define FILE_FIELD_W    5
`define FILE_ADDR_MAX   7'h7f
`define BIT_NUM_W       3
`define LIT_W           9
`define LIT8_W          8
`define OPC_HI          11
`define OPC_LO          10
`define DEST_POS        5
`define BIT_HI          7
`define BIT_LO          5
`define FILE_HI         4
`define LIT8_HI         7
`define LIT9_HI         8
`define GRP_BIT         2'h1
`define CTRL_ZERO_HI    5
`define CTRL_ZERO       7'h00
`define OPC6_HI         11
`define OPC6_LO         6
`define OPC6_DECFSZ     6'h0b
`define OPC6_INCFSZ     6'h0f
`define OPC3_HI         11
`define OPC3_LO         9
`define OPC3_GOTO       3'h5
`define OPC4_HI         11
`define OPC4_LO         8
`define OPC4_CALL       4'h9
`define OPC4_RETURN_LIT 4'h8
`define OPC4_TEST_CLR   4'h6
`define OPC4_TEST_SET   4'h7
`define OPC5_MOVE_W_TO  5'h01
`define OPC5_HI         11
`define OPC5_LO         7
`define PC_LOW_ADDR     7'h02
`define PHASES_PER_CYCLE 4
`define CLK_PERIOD_PS   25000
`define CYCLE_TIME_PS   (`PHASES_PER_CYCLE * `CLK_PERIOD_PS)

`endif

//--- shared/instruction_decode_pkg.sv
// Purpose: Types shared by the decoder modules.
// Assumes: Constants come from instruction_decode_regs.svh.
// Notes: Phase codes are one-hot, one bit per oscillator period.
`include "instruction_decode_regs.svh"
package instruction_decode_pkg;

  typedef enum logic [1:0] {
    CAT_BYTE = 2'h0,
    CAT_BIT  = 2'h1,
    CAT_LIT  = 2'h2
  } category_e;

  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } phase_e;

  typedef struct packed {
    category_e                category;
    logic [`FILE_ADDR_W-1:0]  file_addr;
    logic                     dest_file;
    logic [`BIT_NUM_W-1:0]    bit_num;
    logic [`LIT_W-1:0]        literal;
    logic                     literal_wide;
    logic                     pc_write;
    logic                     pc_bit8_clear;
    logic                     skip_class;
  } fields_s;

endpackage : instruction_decode_pkg

//--- shared/decode_if.sv
// Purpose: Carries the fetched word to the field extractor and the fields back.
// Assumes: Extraction is purely combinational.
// Notes: One modport per side.
`timescale 1ns/1ps
`include "instruction_decode_regs.svh"
interface decode_if;
  logic [`WORD_W-1:0]              word;
  instruction_decode_pkg::fields_s fields;

  modport extract (input word, output fields);
  modport user    (output word, input fields);
endinterface : decode_if

//--- rtl/operand_extract.sv
// Purpose: Split one instruction word into category and operand fields.
// Assumes: Word is stable for the whole evaluation; no state is held here.
// Notes: Fields unused by a category read as zero so unused bits cannot leak.
`timescale 1ns/1ps
module operand_extract (
  decode_if.extract dif   // Word in, decoded fields out.
);
  typedef struct packed {
    instruction_decode_pkg::fields_s f;
  } state_s;

  state_s next_s;

  // Classification and extraction from fixed positions only.
  always_comb begin
    logic [`WORD_W-1:0] w;
    logic               ctrl;
    w = dif.word;
    ctrl = (w[`OPC_HI:`CTRL_ZERO_HI] == `CTRL_ZERO);
    next_s = '0;
    if (w[`OPC_HI:`OPC_LO] == `GRP_BIT) begin
      next_s.f.category  = instruction_decode_pkg::CAT_BIT;
      next_s.f.file_addr = {2'h0, w[`FILE_HI:0]};
      next_s.f.bit_num   = w[`BIT_HI:`BIT_LO];
      next_s.f.skip_class = (w[`OPC4_HI:`OPC4_LO] == `OPC4_TEST_CLR) ||
                            (w[`OPC4_HI:`OPC4_LO] == `OPC4_TEST_SET);
    end else if (w[`OPC_HI] || ctrl) begin
      next_s.f.category = instruction_decode_pkg::CAT_LIT;
      // Only the unconditional branch carries nine literal bits.
      if (w[`OPC3_HI:`OPC3_LO] == `OPC3_GOTO) begin
        next_s.f.literal      = w[`LIT9_HI:0];
        next_s.f.literal_wide = 1'b1;
        next_s.f.pc_write     = 1'b1;
      end else begin
        next_s.f.literal = {1'b0, w[`LIT8_HI:0]};
        if ((w[`OPC4_HI:`OPC4_LO] == `OPC4_CALL) ||
            (w[`OPC4_HI:`OPC4_LO] == `OPC4_RETURN_LIT)) begin
          next_s.f.pc_write      = 1'b1;
          next_s.f.pc_bit8_clear = 1'b1;
        end
      end
    end else begin
      next_s.f.category  = instruction_decode_pkg::CAT_BYTE;
      next_s.f.file_addr = {2'h0, w[`FILE_HI:0]};
      // The move-to-file form has its destination bit fixed at one.
      next_s.f.dest_file = w[`DEST_POS];
      next_s.f.skip_class = (w[`OPC6_HI:`OPC6_LO] == `OPC6_DECFSZ) ||
                            (w[`OPC6_HI:`OPC6_LO] == `OPC6_INCFSZ);
      // A write back into the low program counter byte is a PC change.
      if (next_s.f.dest_file && next_s.f.file_addr == `PC_LOW_ADDR) begin
        next_s.f.pc_write      = 1'b1;
        next_s.f.pc_bit8_clear = 1'b1;
      end
    end
  end

  assign dif.fields = next_s.f;

endmodule : operand_extract

//--- rtl/instruction_format_decode.sv
// Purpose: Sequence instruction cycles and present decoded operand fields.
// Assumes: Fetch word and skip condition come from logic on the same clock.
// Notes: One instruction cycle is four clock periods; the second cycle of a
//        two-cycle instruction is a flush with fields marked invalid.
`timescale 1ns/1ps
`include "instruction_decode_regs.svh"
module instruction_format_decode (
  input  wire logic                   clk,           // Oscillator clock, 40 MHz.
  input  wire logic                   reset,         // Synchronous, active high.
  input  wire logic [`WORD_W-1:0]     instr,         // Fetched word, taken in Q4.
  input  wire logic                   skip_true,     // Datapath test result, read in Q4.
  output logic [3:0]                  phase,         // One-hot Q1..Q4 phase.
  output logic                        cycle_start,   // Pulse in Q1 of every cycle.
  output logic                        exec_valid,    // Fields belong to a live instruction.
  output logic                        flush,         // Current cycle is a flush cycle.
  output logic [1:0]                  category,      // Byte, bit or literal/control.
  output logic [`FILE_ADDR_W-1:0]     file_addr,     // File register address.
  output logic                        dest_file,     // 1: result to file, 0: accumulator.
  output logic [`BIT_NUM_W-1:0]       bit_num,       // Bit selected in the file register.
  output logic [`LIT_W-1:0]           literal,       // Constant operand.
  output logic                        literal_wide,  // Literal is nine bits wide.
  output logic                        pc_write,      // Instruction changes the PC.
  output logic                        pc_bit8_clear, // Force ninth PC bit to zero.
  output logic                        two_cycle      // High in the flush cycle of a two-cycle instruction.
);

  typedef struct packed {
    instruction_decode_pkg::phase_e  phase;
    logic                            flush;
    logic                            valid;
    logic [`WORD_W-1:0]              word;
    instruction_decode_pkg::fields_s f;
    logic                            two;
  } state_s;

  state_s s;
  state_s next_s;

  decode_if dif ();

  // Field extraction runs on the word just fetched so results are ready at Q4.
  assign dif.word = instr;

  operand_extract operand_extract_i (
    .dif (dif)
  );

  // Phase sequencing and instruction capture.
  always_comb begin
    next_s = s;
    unique case (s.phase)
      instruction_decode_pkg::PH_Q1: begin
        next_s.phase = instruction_decode_pkg::PH_Q2;
      end
      instruction_decode_pkg::PH_Q2: begin
        next_s.phase = instruction_decode_pkg::PH_Q3;
      end
      instruction_decode_pkg::PH_Q3: begin
        next_s.phase = instruction_decode_pkg::PH_Q4;
      end
      instruction_decode_pkg::PH_Q4: begin
        next_s.phase = instruction_decode_pkg::PH_Q1;
        // A live instruction that jumps or whose test came out true owns the
        // next cycle too; the word fetched meanwhile is dropped.
        if (s.valid && !s.flush &&
            (s.f.pc_write || (s.f.skip_class && skip_true))) begin
          next_s.flush = 1'b1;
          next_s.two   = 1'b1;
          next_s.valid = 1'b0;
        end else begin
          next_s.flush = 1'b0;
          next_s.two   = 1'b0;
          next_s.valid = 1'b1;
          next_s.word  = instr;
          next_s.f     = dif.fields;
        end
      end
      default: begin
        // Only reachable through a corrupted phase code; restart cleanly.
        next_s.phase = instruction_decode_pkg::PH_Q1;
      end
    endcase
  end

  // State register; reset starts a cycle with nothing valid.
  always_ff @(posedge clk) begin
    if (reset) begin
      s       <= '0;
      s.phase <= instruction_decode_pkg::PH_Q1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state register.
  assign phase         = s.phase;
  assign cycle_start   = (s.phase == instruction_decode_pkg::PH_Q1);
  assign exec_valid    = s.valid;
  assign flush         = s.flush;
  assign category      = s.f.category;
  assign file_addr     = s.f.file_addr;
  assign dest_file     = s.f.dest_file;
  assign bit_num       = s.f.bit_num;
  assign literal       = s.f.literal;
  assign literal_wide  = s.f.literal_wide;
  assign pc_write      = s.f.pc_write;
  assign pc_bit8_clear = s.f.pc_bit8_clear;
  assign two_cycle     = s.two;

endmodule : instruction_format_decode

//--- tb/instruction_decode_checker.sv
// Purpose: Port assertions for the instruction format decoder.
// Assumes: Fields are judged while exec_valid marks a live word.
// Notes: Bound to the decoder top after the module.
`timescale 1ns/1ps
`include "instruction_decode_regs.svh"
module instruction_decode_checker (
  input wire logic                   clk,           // Clock.
  input wire logic                   reset,         // Synchronous reset.
  input wire logic [3:0]             phase,         // One-hot phase.
  input wire logic                   cycle_start,   // Q1 pulse.
  input wire logic                   exec_valid,    // Live word.
  input wire logic                   flush,         // Flush cycle.
  input wire logic [1:0]             category,      // Category code.
  input wire logic                   dest_file,     // Destination select.
  input wire logic [`BIT_NUM_W-1:0]  bit_num,       // Bit number.
  input wire logic [`LIT_W-1:0]      literal,       // Constant operand.
  input wire logic                   literal_wide,  // Nine-bit literal.
  input wire logic                   pc_write,      // PC is written.
  input wire logic                   pc_bit8_clear, // Ninth PC bit cleared.
  input wire logic                   two_cycle      // Extra cycle.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // The four phases must follow one another with no gap or repeat.
  sequence quad_s;
    phase == 4'h1 ##1 phase == 4'h2 ##1 phase == 4'h4 ##1 phase == 4'h8;
  endsequence
  a_phase_walk:   assert property (phase == 4'h1 |-> quad_s) else $error("phase walk");
  a_start_q1:     assert property (cycle_start == (phase == 4'h1)) else $error("start");
  a_fields_stand: assert property (
    phase != 4'h1 |-> $stable({exec_valid, literal, category}))
    else $error("fields moved mid cycle");
  a_flush_once:   assert property (flush && cycle_start |-> ##4 !flush)
    else $error("flush x2");
  a_pc_flush:     assert property (
    exec_valid && pc_write && phase == 4'h8 |=> flush)
    else $error("no flush after pc write");
  a_two_cycle:    assert property (
    two_cycle == flush && !(flush && exec_valid))
    else $error("two cycle flag");
  a_clear_bit8:   assert property (
    exec_valid |-> pc_bit8_clear == (pc_write && !literal_wide))
    else $error("ninth bit clear");
  a_wide_goto:    assert property (
    literal_wide |-> category == 2'h2 && pc_write)
    else $error("wide literal");
  a_narrow_lit:   assert property (
    exec_valid && !literal_wide |-> literal[8] == 1'b0)
    else $error("narrow literal");
  a_dest_byte:    assert property (dest_file |-> category == 2'h0)
    else $error("dest");
  a_bit_cat:      assert property (bit_num != 3'h0 |-> category == 2'h1)
    else $error("bit");
  a_one_cat:      assert property (category != 2'h3) else $error("category");
endmodule : instruction_decode_checker

bind instruction_format_decode instruction_decode_checker chk_i (.clk, .reset, .phase,
  .cycle_start, .exec_valid, .flush, .category, .dest_file, .bit_num, .literal,
  .literal_wide, .pc_write, .pc_bit8_clear, .two_cycle);

//--- tb/fetch_model.sv
// Purpose: Program fetch and datapath test result seen by the decoder.
// Assumes: Words are queued by the bench as {skip, word}.
// Notes: Outside Q4 the lines toggle, so a stale word is never mistaken.
`timescale 1ns/1ps
`include "instruction_decode_regs.svh"
module fetch_model (
  input  wire logic               clk,      // Clock.
  input  wire logic [3:0]         phase,    // Decoder phase.
  output logic [`WORD_W-1:0]      instr,    // Word, valid in Q4 only.
  output logic                    skip_true // Test result, valid in Q4 only.
);
  logic [12:0] q[$];
  task automatic load(input logic [12:0] item);
    q.push_back(item);
  endtask : load
  initial begin
    instr = '0;
    skip_true = 1'b0;
  end
  // One word per instruction cycle, presented for the Q4 capture edge.
  always @(negedge clk) begin
    if (phase == 4'h8 && q.size() > 0) begin
      {skip_true, instr} = q.pop_front();
    end else begin
      {skip_true, instr} = ~{skip_true, instr};
    end
  end
endmodule : fetch_model

//--- tb/test_instruction_format_decode.sv
// Purpose: Self-checking bench for the instruction format decoder.
// Assumes: Expected fields are worked out here from the encoding rules.
// Notes: Each queued note is {flush, category, addr, dest, bit, literal, wide, pcw, clr}.
`timescale 1ns/1ps
`include "instruction_decode_regs.svh"
module test_instruction_format_decode;
  logic clk, reset, skip_true, cycle_start, exec_valid, flush, dest_file;
  logic literal_wide, pc_write, pc_bit8_clear, two_cycle, armed, live, pend, skp;
  logic [`WORD_W-1:0] instr;
  logic [3:0] phase;
  logic [1:0] category;
  logic [6:0] file_addr;
  logic [2:0] bit_num;
  logic [8:0] literal;
  logic [25:0] exp_q[$];
  logic [25:0] n;
  int error_cnt, num_checks;
  instruction_format_decode instruction_format_decode_i (.clk, .reset, .instr, .skip_true,
    .phase, .cycle_start, .exec_valid, .flush, .category, .file_addr, .dest_file, .bit_num,
    .literal, .literal_wide, .pc_write, .pc_bit8_clear, .two_cycle);
  fetch_model fetch_model_i (.clk, .phase, .instr, .skip_true);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Reference decode; control words 0000_000x_xxxx are literal/control.
  function automatic logic [24:0] ref_fields(input logic [11:0] w);
    logic ctl, go, byt, bt, pcw;
    ctl = (w[11:5] == 7'h00);
    go  = (w[11:9] == 3'h5);
    byt = (w[11:10] == 2'h0) && !ctl;
    bt  = (w[11:10] == 2'h1);
    pcw = go || w[11:8] == 4'h9 || w[11:8] == 4'h8 || (byt && w[5] && w[4:0] == 5'h02);
    return {byt ? 2'h0 : bt ? 2'h1 : 2'h2, (byt || bt) ? {2'h0, w[4:0]} : 7'h00, byt && w[5],
      bt ? w[7:5] : 3'h0, go ? w[8:0] : (byt || bt) ? 9'h000 : {1'h0, w[7:0]}, go, pcw,
      pcw && !go};
  endfunction : ref_fields
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // A word fetched while a PC write or a true skip executes is dropped for a flush.
  task automatic feed(input logic [11:0] w, input logic s);
    logic [24:0] f;
    fetch_model_i.load({s, w});
    f = ref_fields(w);
    // The test result of a skip instruction arrives with the word fetched behind it.
    if (live && (pend || (skp && s))) begin
      exp_q.push_back({1'b1, 25'h0});
      live = 1'b0;
    end else begin
      exp_q.push_back({1'b0, f});
      live = 1'b1;
      pend = f[1];
      skp  = w[11:6] == 6'h0b || w[11:6] == 6'h0f || w[11:9] == 3'h3;
    end
  endtask : feed
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // Each Q1 after the first capture brings one note's worth of outputs.
  always @(negedge clk) begin
    if (armed && cycle_start && exp_q.size() > 0) begin
      n = exp_q.pop_front();
      check({29'h0, flush, two_cycle, exec_valid}, {29'h0, n[25], n[25], !n[25]});
      if (!n[25]) check({7'h0, category, file_addr, dest_file, bit_num, literal, literal_wide,
        pc_write, pc_bit8_clear}, {7'h0, n[24:0]});
    end
    if (phase == 4'h8) armed = 1'b1;
  end
  logic [12:0] dir [16] = '{13'h0a05, 13'h0222, 13'h0905, 13'h0c3f, 13'h02d5, 13'h17e3,
    13'h0801, 13'h03c1, 13'h0040, 13'h0760, 13'h1004, 13'h0003, 13'h0005, 13'h05ff,
    13'h0e80, 13'h0f00};
  initial begin
    reset = 1'b1;
    armed = 1'b0;
    live = 1'b0;
    pend = 1'b0;
    skp = 1'b0;
    error_cnt = 0;
    num_checks = 0;
    void'($urandom(72050));
    foreach (dir[i]) feed(dir[i][11:0], dir[i][12]);
    for (int i = 0; i < 300; i++) feed(12'($urandom), 1'($urandom));
    repeat (10) @(negedge clk);
    reset = 1'b0;
    for (int k = 0; k < 6000 && exp_q.size() > 0; k++) @(negedge clk);
    if (exp_q.size() > 0) error_cnt++;
    print_verdict();
  end
endmodule : test_instruction_format_decode
